// file: core/cfr_pkg.sv
// package of register map, field positions and reset values for the clock fault/request block
package cfr_pkg;
    // register byte addresses (aligned words on the register bus)
    localparam logic [7:0]  ADDR_CLK_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_FAULT_FLAGS   = 8'h04;
    localparam logic [7:0]  ADDR_REQ_ENABLES   = 8'h08;
    localparam logic [7:0]  ADDR_SWING_SELECT  = 8'h0C;
    localparam logic [7:0]  ADDR_IRQ_STATUS    = 8'h10;
    localparam logic [7:0]  ADDR_IRQ_ENABLE    = 8'h14;
    localparam logic [7:0]  ADDR_IRQ_CLEAR     = 8'h18;
    localparam logic [7:0]  ADDR_TAP_STATUS    = 8'h1C;

    // clock control word fields
    localparam int BIT_XT1_DISABLE   = 0;
    localparam int BIT_SUB_DISABLE   = 1;
    localparam int BIT_XT1_BYPASS    = 4;
    localparam logic [15:0] CLK_CTRL_RESET = 16'h0001;
    localparam logic [15:0] CLK_CTRL_MASK  = 16'h0013;

    // fault flag fields
    localparam int BIT_DCO_FAULT   = 0;
    localparam int BIT_XT1LF_FAULT = 1;
    localparam int BIT_XT1HF_FAULT = 2;
    localparam int BIT_XT2_FAULT   = 3;
    localparam logic [15:0] FAULT_RESET    = 16'h0F03;
    localparam logic [15:0] FAULT_RW_MASK  = 16'h3C10;
    localparam logic [15:0] FAULT_RO_FIXED = 16'h0300;

    // request enable fields
    localparam int BIT_AUX_REQ = 0;
    localparam int BIT_MAIN_REQ = 1;
    localparam int BIT_SUB_REQ = 2;
    localparam int BIT_MOD_REQ = 3;
    localparam logic [15:0] REQ_RESET   = 16'h0007;
    localparam logic [15:0] REQ_RW_MASK = 16'h000F;

    // bypass swing select
    localparam logic [15:0] SWING_RESET   = 16'h0000;
    localparam logic [15:0] SWING_RW_MASK = 16'h0003;

    // digital oscillator tap limits
    localparam logic [4:0]  TAP_MIN = 5'h00;
    localparam logic [4:0]  TAP_MAX = 5'h1F;

    // interrupt events
    localparam int IRQ_BITS = 4;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: core/cfr_clk_gate.sv
// glitch-free gate for the subsystem clock enable
`timescale 1ns/100ps
module cfr_clk_gate (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic disable_req,
    // gated enable
    output logic      clk_en
);
    logic en_ff;
    logic nxt_en;

    // the enable only changes on a clock edge, so no partial pulse leaves the gate
    always_comb begin
        nxt_en = !disable_req;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_ff <= 1'b1;
        end else begin
            en_ff <= nxt_en;
        end
    end

    assign clk_en = en_ff;
endmodule

// file: core/cfr_ctrl.sv
// clock fault flags, request enables and bypass selects with axi4-lite access
`timescale 1ns/100ps
module cfr_ctrl #(
    parameter bit HAS_XT2  = 1'b1,
    parameter bit HAS_XT1HF = 1'b1
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    // axi4-lite write response
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // oscillator status (asynchronous to aclk)
    input  wire logic        xt1_fault_raw,
    input  wire logic        xt2_fault_raw,
    input  wire logic        xt1_hf_mode,
    input  wire logic        xt1_port_selected,
    input  wire logic        xt1_in_use,
    input  wire logic [4:0]  dco_tap,
    // peripheral conditional requests
    input  wire logic [3:0]  periph_req,
    // oscillator controls
    output logic             subsystem_clock_en,
    output logic             crystal1_power_en,
    output logic             crystal1_bypass_select,
    output logic             crystal1_bypass_swing_level,
    output logic             crystal2_bypass_swing_level,
    output logic [3:0]       clock_req_granted,
    output logic             osc_fault_interrupt_flag,
    output logic             irq
);
    import cfr_pkg::*;

    // two-flop synchronisers for external status
    logic [8:0] sync1_ff, sync2_ff;
    // zeroed synchronisers read as tap 0, so faults wait until real samples arrive
    logic [1:0] prime_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= 9'h000;
            sync2_ff <= 9'h000;
            prime_ff <= 2'h0;
        end else begin
            sync1_ff <= {xt1_fault_raw, xt2_fault_raw, xt1_hf_mode, xt1_port_selected,
                         xt1_in_use, dco_tap[3:0]};
            sync2_ff <= sync1_ff;
            prime_ff <= {prime_ff[0], 1'b1};
        end
    end
    // tap msb synchronised separately to keep width tidy
    logic tap4_s1_ff, tap4_s2_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap4_s1_ff <= 1'b0;
            tap4_s2_ff <= 1'b0;
        end else begin
            tap4_s1_ff <= dco_tap[4];
            tap4_s2_ff <= tap4_s1_ff;
        end
    end
    // multi-bit tap may skew one cycle; a limit glitch only sets a sticky flag
    logic       s_xt1_fault, s_xt2_fault, s_hf, s_port_sel, s_in_use;
    logic [4:0] s_tap;
    assign s_xt1_fault = sync2_ff[8];
    assign s_xt2_fault = sync2_ff[7];
    assign s_hf        = sync2_ff[6];
    assign s_port_sel  = sync2_ff[5];
    assign s_in_use    = sync2_ff[4];
    assign s_tap       = {tap4_s2_ff, sync2_ff[3:0]};

    // registers
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [15:0] fault_ff, nxt_fault;
    logic [15:0] req_ff, nxt_req;
    logic [15:0] swing_ff, nxt_swing;
    logic [3:0]  ist_ff, nxt_ist;
    logic [3:0]  ien_ff, nxt_ien;

    // axi handshake state
    logic        aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
    logic [7:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;

    logic        do_write;
    logic [15:0] wmask, wval;
    logic [3:0]  fault_now;
    logic [15:0] impl_mask;

    // write address and data taken independently, one write in flight
    assign s_awready = !aw_ff && !b_ff;
    assign s_wready  = !w_ff && !b_ff;
    assign s_arready = !r_ff;
    assign s_bvalid  = b_ff;
    assign s_bresp   = bresp_ff;
    assign s_rvalid  = r_ff;
    assign s_rdata   = rdata_ff;
    assign s_rresp   = rresp_ff;
    assign do_write  = aw_ff && w_ff && !b_ff;
    assign wmask     = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign wval      = wdata_ff[15:0];

    // live fault conditions; absent features never report
    always_comb begin
        fault_now[BIT_DCO_FAULT]   = (s_tap == TAP_MIN) || (s_tap == TAP_MAX);
        fault_now[BIT_XT1LF_FAULT] = s_xt1_fault && !s_hf;
        fault_now[BIT_XT1HF_FAULT] = HAS_XT1HF && s_xt1_fault && s_hf;
        fault_now[BIT_XT2_FAULT]   = HAS_XT2 && s_xt2_fault;
        // no false tap-limit event right after reset
        fault_now = fault_now & {4{prime_ff[1]}};
        impl_mask = 16'h0003;
        impl_mask[BIT_XT1HF_FAULT] = HAS_XT1HF;
        impl_mask[BIT_XT2_FAULT]   = HAS_XT2;
    end

    // handshake next state
    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_b = b_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bresp = bresp_ff;
        if (s_awvalid && s_awready) begin
            nxt_aw = 1'b1;
            nxt_awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            nxt_w = 1'b1;
            nxt_wdata = s_wdata;
            nxt_wstrb = s_wstrb;
        end
        if (do_write) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_b = 1'b1;
            unique case (awaddr_ff)
                ADDR_CLK_CTRL, ADDR_FAULT_FLAGS, ADDR_REQ_ENABLES, ADDR_SWING_SELECT,
                ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_IRQ_CLEAR, ADDR_TAP_STATUS:
                    nxt_bresp = RESP_OKAY;
                default: nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (b_ff && s_bready) begin
            nxt_b = 1'b0;
        end
    end

    // register next values
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_fault = fault_ff;
        nxt_req   = req_ff;
        nxt_swing = swing_ff;
        nxt_ien   = ien_ff;
        nxt_ist   = ist_ff;
        if (do_write) begin
            unique case (awaddr_ff)
                ADDR_CLK_CTRL: nxt_ctrl = (ctrl_ff & ~(wmask & CLK_CTRL_MASK))
                                        | (wval & wmask & CLK_CTRL_MASK);
                // software may clear implemented flags; reserved rw bits just store
                ADDR_FAULT_FLAGS: nxt_fault = (fault_ff & ~(wmask & (FAULT_RW_MASK | impl_mask)))
                                            | (wval & wmask & (FAULT_RW_MASK | impl_mask));
                ADDR_REQ_ENABLES: nxt_req = (req_ff & ~(wmask & REQ_RW_MASK))
                                          | (wval & wmask & REQ_RW_MASK);
                ADDR_SWING_SELECT: nxt_swing = (swing_ff & ~(wmask & SWING_RW_MASK))
                                             | (wval & wmask & SWING_RW_MASK);
                ADDR_IRQ_ENABLE: if (wstrb_ff[0]) nxt_ien = wdata_ff[3:0];
                ADDR_IRQ_CLEAR: if (wstrb_ff[0]) nxt_ist = ist_ff & ~wdata_ff[3:0];
                default: ;
            endcase
        end
        // hardware set applied last so a persisting fault beats a clear
        nxt_fault[3:0] = nxt_fault[3:0] | fault_now;
        nxt_ist = nxt_ist | fault_now;
        nxt_fault = (nxt_fault & (FAULT_RW_MASK | impl_mask)) | FAULT_RO_FIXED;
    end

    // read channel
    always_comb begin
        nxt_r = r_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (s_arvalid && s_arready) begin
            nxt_r = 1'b1;
            nxt_rresp = RESP_OKAY;
            unique case (s_araddr)
                ADDR_CLK_CTRL:     nxt_rdata = {16'h0000, ctrl_ff};
                ADDR_FAULT_FLAGS:  nxt_rdata = {16'h0000, fault_ff};
                ADDR_REQ_ENABLES:  nxt_rdata = {16'h0000, req_ff};
                ADDR_SWING_SELECT: nxt_rdata = {16'h0000, swing_ff};
                ADDR_IRQ_STATUS:   nxt_rdata = {28'h000_0000, ist_ff};
                ADDR_IRQ_ENABLE:   nxt_rdata = {28'h000_0000, ien_ff};
                ADDR_IRQ_CLEAR:    nxt_rdata = 32'h0000_0000;
                ADDR_TAP_STATUS:   nxt_rdata = {27'h000_0000, s_tap};
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end else if (r_ff && s_rready) begin
            nxt_r = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            b_ff <= 1'b0;
            r_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bresp_ff <= RESP_OKAY;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff <= CLK_CTRL_RESET;
            fault_ff <= FAULT_RESET;
            req_ff <= REQ_RESET;
            swing_ff <= SWING_RESET;
            ist_ff <= 4'h0;
            ien_ff <= IRQ_ENABLE_RESET;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            b_ff <= nxt_b;
            r_ff <= nxt_r;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bresp_ff <= nxt_bresp;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            fault_ff <= nxt_fault;
            req_ff <= nxt_req;
            swing_ff <= nxt_swing;
            ist_ff <= nxt_ist;
            ien_ff <= nxt_ien;
        end
    end

    // glitch-free subsystem clock enable
    cfr_clk_gate u_gate (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .disable_req (ctrl_ff[BIT_SUB_DISABLE]),
        .clk_en      (subsystem_clock_en)
    );

    // crystal 1 power: on when enabled with port selected, or disabled but in use; bypass needs no oscillator
    assign crystal1_power_en = !ctrl_ff[BIT_XT1_BYPASS] &&
        ((!ctrl_ff[BIT_XT1_DISABLE] && s_port_sel) ||
         (ctrl_ff[BIT_XT1_DISABLE] && s_in_use));
    assign crystal1_bypass_select = ctrl_ff[BIT_XT1_BYPASS];
    assign crystal1_bypass_swing_level = swing_ff[0];
    assign crystal2_bypass_swing_level = swing_ff[1];

    // conditional requests gated per clock
    assign clock_req_granted = periph_req & req_ff[3:0];

    // shared fault flag from any implemented fault flag
    assign osc_fault_interrupt_flag = |(fault_ff[3:0] & impl_mask[3:0]);
    assign irq = |(ist_ff & ien_ff);
endmodule

// file: tb/cfr_ctrl_sva.sv
// port assertions for the clock fault and request block
`timescale 1ns/100ps
module cfr_ctrl_sva
    import cfr_pkg::*;
(
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // bus handshakes
    input wire logic       s_awvalid,
    input wire logic       s_awready,
    input wire logic       s_wvalid,
    input wire logic       s_wready,
    input wire logic       s_bvalid,
    input wire logic       s_bready,
    input wire logic       s_arvalid,
    input wire logic       s_arready,
    input wire logic       s_rvalid,
    input wire logic       s_rready,
    // oscillator and request side
    input wire logic [4:0] dco_tap,
    input wire logic       xt1_in_use,
    input wire logic       xt1_port_selected,
    input wire logic [3:0] periph_req,
    input wire logic       subsystem_clock_en,
    input wire logic       crystal1_power_en,
    input wire logic       crystal1_bypass_select,
    input wire logic [3:0] clock_req_granted,
    input wire logic       osc_fault_interrupt_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken at one edge, then the response
    sequence wr_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence wr_answer;
        ##2 s_bvalid;
    endsequence
    AST_WR_LATENCY: assert property (wr_taken |-> wr_answer)
        else $error("write response late");
    AST_B_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped");
    AST_RD_LATENCY: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid)
        else $error("read data dropped");
    AST_DCO_FAULT: assert property ((dco_tap == TAP_MIN || dco_tap == TAP_MAX) [*4]
        |-> osc_fault_interrupt_flag) else $error("tap limit without fault flag");
    AST_XT1_KEPT: assert property ((xt1_in_use && xt1_port_selected
        && !crystal1_bypass_select) [*4] |-> crystal1_power_en)
        else $error("crystal powered down while in use");
    AST_XT1_IDLE_OFF: assert property ((!xt1_port_selected && !xt1_in_use) [*4]
        |-> !crystal1_power_en) else $error("crystal running while unused");
    AST_GRANT_REQ: assert property ($changed(clock_req_granted) && $stable(periph_req)
        |-> s_bvalid) else $error("grant moved without request or write");
    AST_SUB_BY_WRITE: assert property ($changed(subsystem_clock_en)
        |-> s_bvalid || $past(s_bvalid) || $past(s_bvalid, 2)) else $error("clock gate moved alone");
endmodule
bind cfr_ctrl cfr_ctrl_sva u_cfr_ctrl_sva (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready,
    .s_arvalid, .s_arready, .s_rvalid, .s_rready, .dco_tap, .xt1_in_use, .xt1_port_selected,
    .periph_req,
    .subsystem_clock_en, .crystal1_power_en, .crystal1_bypass_select, .clock_req_granted,
    .osc_fault_interrupt_flag
);

// file: tb/cfr_req_model.sv
// peripheral side model raising conditional clock requests
`timescale 1ns/100ps
module cfr_req_model (
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // wanted requests and delay before raising them
    input wire logic [3:0] want,
    input wire logic [3:0] lag,
    // request lines
    output logic [3:0]     periph_req
);
    logic [3:0] want_ff;
    logic [3:0] cnt_ff;
    // new requests wait lag cycles so slow peripherals are seen; drops are immediate
    always_ff @(posedge aclk) begin
        want_ff <= want;
        if (!aresetn) begin
            cnt_ff     <= 4'h0;
            periph_req <= 4'h0;
        end else if (want != want_ff) begin
            cnt_ff     <= lag;
            periph_req <= want & periph_req;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else begin
            periph_req <= want;
        end
    end
endmodule

// file: tb/clock_fault_request_ctrl_bench.sv
// self-checking bench for the clock fault and request block
`timescale 1ns/100ps
module clock_fault_request_ctrl_bench;
    import cfr_pkg::*;
    typedef struct packed {
        logic [7:0]  a;
        logic [15:0] d;
        logic [15:0] e;
        logic [1:0]  r;
        logic [1:0]  si;
        logic [4:0]  o;
    } cfr_row_t;
    logic        aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready, xt1_fault_raw, xt2_fault_raw;
    logic        xt1_hf_mode, xt1_port_selected, xt1_in_use, subsystem_clock_en, irq;
    logic        crystal1_power_en, crystal1_bypass_select, crystal1_bypass_swing_level;
    logic        crystal2_bypass_swing_level, osc_fault_interrupt_flag;
    logic [1:0]  s_bresp, s_rresp, cap_r;
    logic [3:0]  s_wstrb, periph_req, clock_req_granted, want, lag;
    logic [4:0]  dco_tap, outs;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, cap_d;
    int          fails, checked;
    // address, write, read back, response, {port select, in use}, expected levels
    cfr_row_t rows [11] = '{
        '{ADDR_CLK_CTRL, 16'h0002, 16'h0002, RESP_OKAY, 2'h2, 5'h08},
        '{ADDR_CLK_CTRL, 16'h0010, 16'h0010, RESP_OKAY, 2'h2, 5'h14},
        '{ADDR_CLK_CTRL, 16'h0011, 16'h0011, RESP_OKAY, 2'h2, 5'h14},
        '{ADDR_CLK_CTRL, 16'h0001, 16'h0001, RESP_OKAY, 2'h1, 5'h18},
        '{ADDR_CLK_CTRL, 16'h0000, 16'h0000, RESP_OKAY, 2'h3, 5'h18},
        '{ADDR_SWING_SELECT, 16'h0003, 16'h0003, RESP_OKAY, 2'h0, 5'h13},
        '{ADDR_SWING_SELECT, 16'hFFFC, 16'h0000, RESP_OKAY, 2'h0, 5'h10},
        '{ADDR_REQ_ENABLES, 16'h070F, 16'h000F, RESP_OKAY, 2'h0, 5'h10},
        '{ADDR_FAULT_FLAGS, 16'hC0E0, 16'h0300, RESP_OKAY, 2'h0, 5'h10},
        '{8'h20, 16'h1234, 16'h0000, RESP_SLVERR, 2'h0, 5'h10},
        '{ADDR_IRQ_CLEAR, 16'h000F, 16'h0000, RESP_OKAY, 2'h0, 5'h10}};
    // {tap, xt1 fault, high-frequency mode, xt2 fault} and the flag each must raise
    logic [7:0]  fcase [5] = '{8'h00, 8'hF8, 8'h84, 8'h86, 8'h81};
    logic [15:0] fbit [5] = '{16'h0001, 16'h0001, 16'h0002, 16'h0004, 16'h0008};
    logic [7:0]  raddr [7] = '{ADDR_CLK_CTRL, ADDR_FAULT_FLAGS, ADDR_REQ_ENABLES,
                                ADDR_SWING_SELECT, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE,
                                ADDR_TAP_STATUS};
    logic [15:0] rval [7] = '{CLK_CTRL_RESET, FAULT_RESET, REQ_RESET, SWING_RESET,
                               16'h0000, 16'h0000, 16'h0010};
    assign outs = {subsystem_clock_en, crystal1_power_en, crystal1_bypass_select,
                   crystal2_bypass_swing_level, crystal1_bypass_swing_level};
    cfr_ctrl u_cfr_ctrl (
        .aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .xt1_fault_raw, .xt2_fault_raw, .xt1_hf_mode,
        .xt1_port_selected, .xt1_in_use, .dco_tap, .periph_req, .subsystem_clock_en,
        .crystal1_power_en, .crystal1_bypass_select, .crystal1_bypass_swing_level,
        .crystal2_bypass_swing_level, .clock_req_granted, .osc_fault_interrupt_flag, .irq);
    cfr_req_model u_cfr_req_model (.aclk, .aresetn, .want, .lag, .periph_req);
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // bounded wait for bvalid, arready or rvalid; answer caught before the taking edge
    task automatic waitk(input int k, inout int n);
        logic t;
        do begin
            @(negedge aclk);
            t = (k == 0) ? s_bvalid : (k == 1) ? s_arready : s_rvalid;
            cap_r = (k == 0) ? s_bresp : s_rresp;
            cap_d = s_rdata;
            n++;
            @(posedge aclk);
        end while (t !== 1'b1 && n < 40);
    endtask
    // optional write, then a read of the same word, both checked
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [15:0] d,
                        input logic [15:0] e, input logic [1:0] er);
        int   n;
        logic pa, pw, ta, tw;
        n = 0;
        pa = wr;
        pw = wr;
        @(posedge aclk);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= {16'h0000, d};
        s_awvalid <= wr;
        s_wvalid <= wr;
        s_bready <= wr;
        while ((pa || pw) && n < 40) begin
            @(negedge aclk);
            ta = pa && s_awready;
            tw = pw && s_wready;
            n++;
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        if (wr) begin
            waitk(0, n);
            s_bready <= 1'b0;
            chk("bresp", 32'(er), 32'(cap_r));
        end
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        waitk(1, n);
        s_arvalid <= 1'b0;
        waitk(2, n);
        s_rready <= 1'b0;
        if (n >= 40) begin
            fails++;
            $display("MISMATCH bus wait expected answer seen none");
            close_out();
        end else begin
            chk("rdata", {16'h0000, e}, cap_d);
            chk("rresp", 32'(er), 32'(cap_r));
        end
    endtask
    initial begin
        {fails, checked} = '0;
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata, want, lag} = '0;
        {xt1_fault_raw, xt2_fault_raw, xt1_hf_mode, xt1_port_selected, xt1_in_use} = '0;
        s_wstrb = 4'h3;
        dco_tap = 5'h10;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            {xt1_port_selected, xt1_in_use} <= rows[i].si;
            xfer(1'b1, rows[i].a, rows[i].d, rows[i].e, rows[i].r);
            repeat (4) @(posedge aclk);
            chk("levels", 32'(rows[i].o), 32'(outs));
        end
        // each fault held while software clears it, then gone and cleared
        xfer(1'b1, ADDR_IRQ_ENABLE, 16'h000F, 16'h000F, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            {dco_tap, xt1_fault_raw, xt1_hf_mode, xt2_fault_raw} <= fcase[i];
            repeat (6) @(posedge aclk);
            xfer(1'b1, ADDR_FAULT_FLAGS, 16'h0000, 16'h0300 | fbit[i], RESP_OKAY);
            chk("fault", 32'h1, 32'(osc_fault_interrupt_flag));
            chk("irq", 32'h1, 32'(irq));
            {dco_tap, xt1_fault_raw, xt1_hf_mode, xt2_fault_raw} <= 8'h80;
            repeat (6) @(posedge aclk);
            xfer(1'b1, ADDR_IRQ_CLEAR, 16'h000F, 16'h0000, RESP_OKAY);
            xfer(1'b1, ADDR_FAULT_FLAGS, 16'h0000, 16'h0300, RESP_OKAY);
            chk("fault", 32'h0, 32'(osc_fault_interrupt_flag));
            chk("irq", 32'h0, 32'(irq));
        end
        // masked then unmasked interrupt on a standing fault
        dco_tap <= 5'h00;
        xfer(1'b1, ADDR_IRQ_ENABLE, 16'h0000, 16'h0000, RESP_OKAY);
        chk("irq", 32'h0, 32'(irq));
        xfer(1'b1, ADDR_IRQ_ENABLE, 16'h0001, 16'h0001, RESP_OKAY);
        chk("irq", 32'h1, 32'(irq));
        dco_tap <= 5'h10;
        // slow peripheral asks for every clock, one enable at a time
        want <= 4'hF;
        lag <= 4'h5;
        // the model holds new requests back for lag cycles
        repeat (8) @(posedge aclk);
        for (int i = 0; i <= 4; i++) begin
            xfer(1'b1, ADDR_REQ_ENABLES, 16'h0700 | 16'((16'h0001 << i) & 16'h000F),
                 16'((16'h0001 << i) & 16'h000F), RESP_OKAY);
            chk("grant", 32'((4'h1 << i) & 4'hF), 32'(clock_req_granted));
        end
        // second reset in mid-run restores every register
        want <= 4'h0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("clock on", 32'h1, 32'(subsystem_clock_en));
        chk("fault", 32'h1, 32'(osc_fault_interrupt_flag));
        for (int i = 0; i < 7; i++) begin
            xfer(1'b0, raddr[i], 16'h0000, rval[i], RESP_OKAY);
        end
        close_out();
    end
endmodule
